//--- logic/usbdsc_pkg.sv
// constants, types and register map of the descriptor builder
// What this block does
// (RULE_01) companion descriptor holds two-byte bytes-per-interval at byte offset four
// (RULE_02) iso without extended flag reports the reserved per-interval byte count
// (RULE_03) iso with extended flag reports one; true count in extended descriptor
// (RULE_04) control and bulk endpoints report bytes-per-interval as zero
// (RULE_05) extended iso descriptor sent only while running above Gen 1
// (RULE_06) extended descriptor provided whenever iso endpoint needs over 48K per interval; the code provides it only while the fast bit is set
// (RULE_07) extended descriptor only inside configuration set; direct request refused
// (RULE_08) extended descriptor sits right after companion, which follows the endpoint
// (RULE_09) selected alternate setting runs endpoint with the extended descriptor's figures
// (RULE_10) extended layout: length, type, zero reserved word, four-byte count at four
// (RULE_11) four-byte count stays below Gen1 max times lanes times mantissa over five
// (RULE_12) without strings every string index field reports zero
// (RULE_13) string text is sent as little-endian sixteen-bit code units
// (RULE_14) string index zero: length N+2, type, then two-byte language ids
// (RULE_15) no language id array when the device offers no strings
// (RULE_16) language array has no null end; size is first byte minus two
// (RULE_17) text string: length, type, unterminated text; length minus two bytes
// (RULE_18) host names the wanted language with a sixteen-bit id
// (RULE_19) every returned descriptor starts with its own length byte
// (RULE_20) extended flag is bit seven of companion attributes; multiplier then ignored
// (RULE_21) Gen1 per-interval iso maximum is 48 times 1024 bytes
// (RULE_22) Gen1 lane speed mantissa is five
// (RULE_23) fields go out least significant byte first, offsets in increasing order
package usbdsc_pkg;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BPI = 8'h04;
  localparam logic [7:0] REG_LANG = 8'h08;
  localparam logic [7:0] REG_STR_LEN = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_OP_BPI = 8'h14;
  localparam logic [7:0] REG_STR_BASE = 8'h20;
  localparam int STR_UNITS = 8;
  localparam int LANG_IDS = 2;

  // control register fields
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_STR_EN_BIT = 1;
  localparam int CTRL_TYPE_LSB = 2;
  localparam int CTRL_EXT_BIT = 4;
  localparam int CTRL_MULT_LSB = 5;
  localparam int CTRL_LANES_LSB = 8;
  localparam int CTRL_MANT_LSB = 12;
  localparam int CTRL_BURST_LSB = 16;
  localparam int CTRL_NLANG_BIT = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_5101;

  localparam logic [1:0] EP_CONTROL = 2'h0;
  localparam logic [1:0] EP_ISO = 2'h1;
  localparam logic [1:0] EP_BULK = 2'h2;
  localparam logic [1:0] EP_INTR = 2'h3;

  localparam logic [31:0] MAX_ISO_GEN1 = 32'd48 * 32'd1024;
  localparam logic [31:0] MANT_GEN1 = 32'h0000_0005;
  localparam int ATTR_EXT_BIT = 7;

  localparam logic [7:0] COMP_LEN = 8'h06;
  localparam logic [7:0] EXT_LEN = 8'h08;
  localparam logic [7:0] STR_HDR_LEN = 8'h02;
  localparam logic [7:0] BPI_LO_OFS = 8'h04;

  // descriptor type codes, plain defaults for the top parameters
  localparam logic [7:0] DEF_COMP_TYPE = 8'h01;
  localparam logic [7:0] DEF_EXT_TYPE = 8'h02;
  localparam logic [7:0] DEF_STR_TYPE = 8'h03;

  typedef enum logic [1:0] {
    USBDSC_REQ_CONFIG = 2'b00,
    USBDSC_REQ_STRING = 2'b01,
    USBDSC_REQ_EXT = 2'b10
  } usbdsc_kind_t;

  typedef struct packed {
    usbdsc_kind_t kind;
    logic [7:0] index;
    logic [15:0] langid;
  } usbdsc_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } usbdsc_bus_t;

  typedef enum logic [0:0] {
    USBDSC_IDLE = 1'b0,
    USBDSC_SEND = 1'b1
  } usbdsc_state_t;

endpackage : usbdsc_pkg

//--- logic/usbdsc_top.sv
// descriptor builder: endpoint companion, extended iso companion and strings
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module usbdsc_top #(
  parameter logic [7:0] COMP_TYPE = usbdsc_pkg::DEF_COMP_TYPE,
  parameter logic [7:0] EXT_TYPE = usbdsc_pkg::DEF_EXT_TYPE,
  parameter logic [7:0] STR_TYPE = usbdsc_pkg::DEF_STR_TYPE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire usbdsc_pkg::usbdsc_bus_t bus,
  output logic [31:0] rd_data,
  input wire logic req_valid,
  input wire usbdsc_pkg::usbdsc_req_t req,
  output logic req_refused,
  input wire logic alt_select,
  output logic [31:0] op_bpi,
  output logic [7:0] str_index_field,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  import usbdsc_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] bpi;
  logic [31:0] lang;
  logic [3:0] str_len;
  logic [15:0] str_unit [STR_UNITS];
  usbdsc_state_t state;
  usbdsc_kind_t cur_kind;
  logic [7:0] cur_index;
  logic [7:0] pos;
  logic [7:0] total;
  logic [7:0] next_pos;

  logic fast;
  logic str_en;
  logic [1:0] ep_type;
  logic is_iso;
  logic ext_on;
  logic [15:0] comp_bpi;
  logic [7:0] comp_attr;
  logic [3:0] lanes;
  logic [3:0] mant;
  logic [39:0] limit_lhs;
  logic [39:0] limit_rhs;
  logic over_limit;
  logic [7:0] lang_cnt;
  logic lang_hit;
  logic accept;
  logic [7:0] req_len;

  assign fast = ctrl[CTRL_FAST_BIT];
  assign str_en = ctrl[CTRL_STR_EN_BIT];
  assign ep_type = ctrl[CTRL_TYPE_LSB +: 2];
  assign lanes = ctrl[CTRL_LANES_LSB +: 4];
  assign mant = ctrl[CTRL_MANT_LSB +: 4];
  assign is_iso = (ep_type == EP_ISO);
  assign lang_cnt = ctrl[CTRL_NLANG_BIT] ? 8'h02 : 8'h01;

  // extended companion exists only above Gen 1, forced on beyond the Gen1 cap
  assign ext_on = fast && is_iso && (ctrl[CTRL_EXT_BIT] || (bpi > MAX_ISO_GEN1)); // RULE_05 RULE_06

  always_comb begin
    if (ep_type == EP_CONTROL || ep_type == EP_BULK) begin
      comp_bpi = 16'h0000; // RULE_04
    end else if (ext_on) begin
      comp_bpi = 16'h0001; // RULE_03
    end else if (bpi[31:16] != 16'h0000) begin
      comp_bpi = 16'hFFFF; // saturate: slow link cannot carry more anyway
    end else begin
      comp_bpi = bpi[15:0]; // RULE_02
    end
  end

  // multiplier bits are dropped when the extended flag is up
  always_comb begin
    comp_attr = 8'h00;
    if (is_iso) begin
      comp_attr[ATTR_EXT_BIT] = ext_on; // RULE_20
      comp_attr[1:0] = ext_on ? 2'b00 : ctrl[CTRL_MULT_LSB +: 2];
    end
  end

  // bound cross-multiplied by the gen1 mantissa: no divider and no truncation
  assign limit_lhs = {8'h00, bpi} * {8'h00, MANT_GEN1}; // RULE_22
  assign limit_rhs = {8'h00, MAX_ISO_GEN1} * {36'h0, lanes} * {36'h0, mant}; // RULE_21
  assign over_limit = ext_on && (limit_lhs >= limit_rhs); // RULE_11

  assign str_index_field = str_en ? 8'h01 : 8'h00; // RULE_12

  assign lang_hit = (req.langid == lang[15:0]) ||
    (ctrl[CTRL_NLANG_BIT] && req.langid == lang[31:16]); // RULE_18

  always_comb begin
    accept = 1'b0;
    req_len = 8'h00;
    unique case (req.kind)
      USBDSC_REQ_CONFIG: begin
        accept = 1'b1;
        req_len = ext_on ? (COMP_LEN + EXT_LEN) : COMP_LEN; // RULE_08
      end
      USBDSC_REQ_STRING: begin
        if (str_en && req.index == 8'h00) begin
          accept = 1'b1; // RULE_15
          req_len = STR_HDR_LEN + {lang_cnt[6:0], 1'b0}; // RULE_14 RULE_16
        end else if (str_en && req.index == 8'h01 && lang_hit) begin
          accept = 1'b1;
          req_len = STR_HDR_LEN + {3'h0, str_len, 1'b0}; // RULE_17
        end
      end
      USBDSC_REQ_EXT: begin
        accept = 1'b0; // RULE_07
      end
      default: begin
        accept = 1'b0;
      end
    endcase
  end

  function automatic logic [7:0] desc_byte(input logic [7:0] p);
    logic [7:0] q;
    logic [7:0] u;
    q = p - COMP_LEN;
    u = (p - STR_HDR_LEN) >> 1;
    desc_byte = 8'h00;
    if (cur_kind == USBDSC_REQ_CONFIG) begin
      if (p < COMP_LEN) begin
        unique case (p[2:0])
          3'h0: desc_byte = COMP_LEN; // RULE_19
          3'h1: desc_byte = COMP_TYPE;
          3'h2: desc_byte = {4'h0, ctrl[CTRL_BURST_LSB +: 4]};
          3'h3: desc_byte = comp_attr;
          3'h4: desc_byte = comp_bpi[7:0]; // RULE_01 RULE_23
          3'h5: desc_byte = comp_bpi[15:8];
          default: desc_byte = 8'h00;
        endcase
      end else begin
        unique case (q[2:0])
          3'h0: desc_byte = EXT_LEN; // RULE_10
          3'h1: desc_byte = EXT_TYPE;
          3'h4: desc_byte = bpi[7:0];
          3'h5: desc_byte = bpi[15:8];
          3'h6: desc_byte = bpi[23:16];
          3'h7: desc_byte = bpi[31:24];
          default: desc_byte = 8'h00;
        endcase
      end
    end else if (p == 8'h00) begin
      desc_byte = total; // RULE_19
    end else if (p == 8'h01) begin
      desc_byte = STR_TYPE;
    end else if (cur_index == 8'h00) begin
      // ids counted from offset two, so the id index is u, not p
      desc_byte = u[0] ? (p[0] ? lang[31:24] : lang[23:16]) :
        (p[0] ? lang[15:8] : lang[7:0]); // RULE_14
    end else begin
      desc_byte = p[0] ? str_unit[u[2:0]][15:8] : str_unit[u[2:0]][7:0]; // RULE_13
    end
  endfunction : desc_byte

  // control and configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
      bpi <= 32'h0000_0000;
      lang <= 32'h0000_0000;
      str_len <= 4'h0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        REG_CTRL: ctrl <= bus.wdata;
        REG_BPI: bpi <= bus.wdata;
        REG_LANG: lang <= bus.wdata;
        REG_STR_LEN: str_len <= (bus.wdata[3:0] > 4'h8) ? 4'h8 : bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < STR_UNITS; i++) begin : g_str
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          str_unit[i] <= 16'h0000;
        end else if (bus.wr && bus.addr == REG_STR_BASE + 8'(4 * i)) begin
          str_unit[i] <= bus.wdata[15:0];
        end
      end
    end
  endgenerate

  // operating bytes per interval taken when the alternate setting is chosen
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_bpi <= 32'h0000_0000;
    end else if (alt_select) begin
      op_bpi <= ext_on ? bpi : {16'h0000, comp_bpi}; // RULE_09
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 32'h0000_0000;
    end else if (bus.rd) begin
      if (bus.addr >= REG_STR_BASE && bus.addr < REG_STR_BASE + 8'(4 * STR_UNITS) &&
          bus.addr[1:0] == 2'b00) begin
        rd_data <= {16'h0000, str_unit[3'((bus.addr - REG_STR_BASE) >> 2)]};
      end else begin
        unique case (bus.addr)
          REG_CTRL: rd_data <= ctrl;
          REG_BPI: rd_data <= bpi;
          REG_LANG: rd_data <= lang;
          REG_STR_LEN: rd_data <= {28'h0, str_len};
          REG_STATUS: rd_data <= {16'h0, comp_bpi[7:0], 4'h0, state == USBDSC_SEND,
            over_limit, ext_on, str_en};
          REG_OP_BPI: rd_data <= op_bpi;
          default: rd_data <= 32'h0000_0000;
        endcase
      end
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // request refusal shown as a one-cycle pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_refused <= 1'b0;
    end else begin
      req_refused <= req_valid && state == USBDSC_IDLE && !accept; // RULE_07 RULE_15
    end
  end

  assign next_pos = pos + 8'h01;

  // byte streamer; requests while busy are ignored
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= USBDSC_IDLE;
      cur_kind <= USBDSC_REQ_CONFIG;
      cur_index <= 8'h00;
      total <= 8'h00;
      pos <= 8'h00;
    end else begin
      unique case (state)
        USBDSC_IDLE: begin
          if (req_valid && accept) begin
            state <= USBDSC_SEND;
            cur_kind <= req.kind;
            cur_index <= req.index;
            total <= req_len;
            pos <= 8'h00;
          end
        end
        USBDSC_SEND: begin
          if (tx_ready) begin
            pos <= next_pos; // RULE_23
            if (next_pos == total) begin
              state <= USBDSC_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign tx_valid = (state == USBDSC_SEND);
  assign tx_last = tx_valid && (next_pos == total);

  // data byte registered one step ahead of the position counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_data <= 8'h00;
    end else if (state == USBDSC_IDLE) begin
      tx_data <= (req.kind == USBDSC_REQ_CONFIG) ? COMP_LEN : req_len; // RULE_19
    end else if (tx_ready) begin
      tx_data <= desc_byte(next_pos);
    end
  end

endmodule : usbdsc_top

//--- testbench/usbdsc_checker.sv
// concurrent checks on the request and stream ports of the descriptor builder
`timescale 1ns/1ps
module usbdsc_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire usbdsc_pkg::usbdsc_req_t req,
  input wire logic req_refused,
  input wire logic alt_select,
  input wire logic [31:0] op_bpi,
  input wire logic [7:0] str_index_field,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  import usbdsc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // a request only counts while the streamer is idle
  wire taken = req_valid && !tx_valid;
  property p_ext; taken && req.kind == USBDSC_REQ_EXT |=> req_refused && !tx_valid; endproperty
  a_ext: assert property (p_ext) else $error("direct extended request served");
  property p_nostr; taken && req.kind == USBDSC_REQ_STRING && str_index_field == 8'h00
    |=> req_refused && !tx_valid; endproperty
  a_nostr: assert property (p_nostr) else $error("string sent while disabled");
  property p_len; taken && req.kind == USBDSC_REQ_CONFIG |=> tx_valid && tx_data == COMP_LEN;
  endproperty
  a_len: assert property (p_len) else $error("first byte is not the length");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_end; tx_valid && tx_last && tx_ready |=> !tx_valid; endproperty
  a_end: assert property (p_end) else $error("stream ran past its length");
  property p_last; tx_valid && tx_ready && !tx_last |=> tx_valid; endproperty
  a_last: assert property (p_last) else $error("stream ended without last byte");
  property p_idle; !tx_valid && !req_valid |=> !tx_valid; endproperty
  a_idle: assert property (p_idle) else $error("stream without a request");
  property p_cause; req_refused |-> $past(req_valid) && !$past(tx_valid); endproperty
  a_cause: assert property (p_cause) else $error("refusal without a request");
  property p_op; !alt_select |=> $stable(op_bpi); endproperty
  a_op: assert property (p_op) else $error("operating rate moved without selection");
endmodule : usbdsc_checker

//--- testbench/usbdsc_host_model.sv
// host-side sink of the descriptor byte stream, stalling at random when slow
`timescale 1ns/1ps
module usbdsc_host_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rx_q[$];
  logic [7:0] lfsr = 8'hA5;
  assign tx_ready = !slow || lfsr[0];
  // no null end expected: the length byte alone tells where the descriptor stops
  always @(posedge ref_clk) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    if (tx_valid && tx_ready) rx_q.push_back(tx_data);
  end
endmodule : usbdsc_host_model

//--- testbench/tb_top.sv
// self-checking bench for the descriptor builder
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import usbdsc_pkg::*;
  typedef logic [7:0] usbdsc_bq_t[$];
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic alt_select = 1'b0;
  logic slow = 1'b0;
  usbdsc_bus_t bus = '0;
  usbdsc_req_t req = '0;
  logic [31:0] rd_data, op_bpi, seed = 32'd94;
  logic [7:0] str_index_field, tx_data;
  logic req_refused, tx_valid, tx_last, tx_ready;
  int errors = 0;
  int comparisons = 0;
  usbdsc_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
    .req_valid(req_valid), .req(req), .req_refused(req_refused), .alt_select(alt_select),
    .op_bpi(op_bpi), .str_index_field(str_index_field), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  usbdsc_host_model i_host (.ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic usbdsc_bq_t exp_cfg(logic [31:0] c, logic [31:0] b);
    logic ext;
    logic [15:0] w;
    usbdsc_bq_t q;
    ext = c[0] && c[3:2] == EP_ISO && (c[4] || b > MAX_ISO_GEN1);
    w = (c[3:2] == EP_CONTROL || c[3:2] == EP_BULK) ? 16'h0 : ext ? 16'h1 :
      (b > 32'hFFFF) ? 16'hFFFF : b[15:0];
    q = '{COMP_LEN, DEF_COMP_TYPE, {4'h0, c[19:16]},
      {ext, 5'h0, (c[3:2] == EP_ISO && !ext) ? c[6:5] : 2'h0}, w[7:0], w[15:8]};
    if (ext) q = {q, EXT_LEN, DEF_EXT_TYPE, 8'h00, 8'h00, b[7:0], b[15:8], b[23:16], b[31:24]};
    return q;
  endfunction : exp_cfg
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  // bounded wait: a stuck stream ends the request instead of hanging the run
  task automatic ask(input usbdsc_kind_t k, input logic [7:0] i, input logic [15:0] l,
    output logic r);
    int n;
    i_host.rx_q.delete();
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{kind: k, index: i, langid: l};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1 r = req_refused;
    n = 0;
    while (tx_valid && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask : ask
  task automatic cmp_q(input usbdsc_bq_t e);
    `CHK("stream length", e.size(), i_host.rx_q.size())
    foreach (e[k]) if (k < i_host.rx_q.size()) `CHK("stream byte", e[k], i_host.rx_q[k])
  endtask : cmp_q
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    logic [31:0] c, b, s, lang;
    logic [15:0] un[8];
    logic r;
    int n;
    usbdsc_bq_t q;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(REG_CTRL, s);
    `CHK("ctrl reset", CTRL_RESET, s)
    rd(8'hFC, s);
    `CHK("unmapped read", 32'h0, s)
    for (int i = 0; i < 16; i++) begin
      slow <= i[0];
      s = rnd();
      c = (s & 32'h000F_0010) | 32'h0000_5100 | 32'((i % 4) * 4) | 32'((s[9:8] % 3) * 32);
      c[0] = i < 12;
      c[9] = s[10] && i != 1;
      c[4] = (c[4] | (i == 1)) & (i != 9);
      b = rnd() & 32'h0003_FFFF;
      if (i < 8) b = (i < 4) ? MAX_ISO_GEN1 : MAX_ISO_GEN1 + 1;
      if (i == 9) b[17:16] = 2'b00;
      if (i > 11) b[16] = 1'b1;
      wr(REG_CTRL, c);
      wr(REG_BPI, b);
      q = exp_cfg(c, b);
      ask(USBDSC_REQ_CONFIG, 8'h00, 16'h0, r);
      cmp_q(q);
      rd(REG_STATUS, s);
      r = q.size() == 14 && 64'(b) * MANT_GEN1 >= 64'(MAX_ISO_GEN1) * c[11:8] * c[15:12];
      `CHK("over limit", r, s[2])
      `CHK("ext on", q.size() == 14, s[1])
      `CHK("status bpi", q[4], s[15:8])
      @(posedge ref_clk);
      alt_select <= 1'b1;
      @(posedge ref_clk);
      alt_select <= 1'b0;
      #1 `CHK("op bpi", q.size() == 14 ? b : {16'h0, q[5], q[4]}, op_bpi)
    end
    slow <= 1'b1;
    lang = rnd() & 32'hFFFE_FFFE;
    wr(REG_LANG, lang);
    for (int k = 0; k < 8; k++) begin
      s = rnd();
      un[k] = s[15:0];
      wr(REG_STR_BASE + 8'(4 * k), s);
    end
    wr(REG_CTRL, 32'h0010_5103);
    #1 `CHK("index field on", 8'h01, str_index_field)
    ask(USBDSC_REQ_STRING, 8'h00, 16'h0, r);
    q = '{8'h06, DEF_STR_TYPE, lang[7:0], lang[15:8], lang[23:16], lang[31:24]};
    cmp_q(q);
    for (int j = 0; j < 2; j++) begin
      n = j ? 8 : rnd() % 8;
      wr(REG_STR_LEN, 32'(n));
      q = '{8'(2 + 2 * n), DEF_STR_TYPE};
      for (int k = 0; k < n; k++) q = {q, un[k][7:0], un[k][15:8]};
      ask(USBDSC_REQ_STRING, 8'h01, j ? lang[31:16] : lang[15:0], r);
      cmp_q(q);
    end
    wr(REG_CTRL, 32'h0000_5103);
    ask(USBDSC_REQ_STRING, 8'h00, 16'h0, r);
    q = '{8'h04, DEF_STR_TYPE, lang[7:0], lang[15:8]};
    cmp_q(q);
    for (int j = 0; j < 4; j++) begin
      if (j == 3) wr(REG_CTRL, CTRL_RESET);
      ask(j == 2 ? USBDSC_REQ_EXT : USBDSC_REQ_STRING, 8'(j == 1 ? 2 : j == 0),
        lang[15:0] | 16'h1, r);
      `CHK("refused", 1'b1, r)
      `CHK("nothing sent", 0, i_host.rx_q.size())
    end
    `CHK("index field off", 8'h00, str_index_field)
    end_of_test();
  end
endmodule : tb_top
bind usbdsc_top usbdsc_checker i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .req_refused(req_refused), .alt_select(alt_select),
  .op_bpi(op_bpi), .str_index_field(str_index_field), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_ready(tx_ready));
